//--- src/dir_pkg.sv
// package for the identification register bank: register indices,
// field layout, fixed field values and the readable words.
// assumes a 16-bit register space reached over a 32-bit wishbone bus.
`default_nettype none

package dir_pkg;

  // ==========================================================
  // register indices (byte address on the bus is four times these)
  localparam logic [15:0] IDX_PROG_VOLT  = 16'hF078;
  localparam logic [15:0] IDX_MEMORY     = 16'hF07A;
  localparam logic [15:0] IDX_PART_CODE  = 16'hF07C;
  localparam logic [15:0] IDX_MAKER_CODE = 16'hF07E;

  // ==========================================================
  // field positions
  localparam int MAKER_FIELD_LSB = 5;
  localparam int PART_FIELD_LSB  = 4;
  localparam int MEM_KIND_LSB    = 12;
  localparam int PROG_HV_LSB     = 8;

  // ==========================================================
  // fixed contents
  localparam logic [4:0]  MAKER_LOW_BITS   = 5'h03;
  localparam int          MEM_SIZE_KBYTES  = 832;
  localparam int          MEM_SIZE_UNIT_KB = 4;
  localparam logic [11:0] MEM_SIZE_FIELD   =
    12'(MEM_SIZE_KBYTES / MEM_SIZE_UNIT_KB);
  localparam logic [3:0]  MEM_KIND_NONE    = 4'h0;
  localparam logic [3:0]  MEM_KIND_MROM    = 4'h1;
  localparam logic [3:0]  MEM_KIND_FLASH   = 4'h2;
  localparam logic [3:0]  MEM_KIND_HPFLASH = 4'h3;
  localparam logic [3:0]  MEM_KIND_BUSY    = 4'hF;
  localparam int          PROG_SUPPLY_MV   = 5000;
  localparam int          PROG_SCALE_V     = 20;
  localparam int          PROG_SCALE_DIV   = 256;
  localparam logic [7:0]  PROG_SUPPLY_FIELD =
    8'(PROG_SUPPLY_MV * PROG_SCALE_DIV / (PROG_SCALE_V * 1000));
  localparam logic [7:0]  PROG_HV_FIELD    = 8'h00;

  // ==========================================================
  // readable words
  localparam logic [15:0] PROG_RESET_VALUE = 16'h0040;
  localparam logic [15:0] MEM_RESET_VALUE  = 16'h30D0;
  localparam logic [15:0] MEM_BUSY_VALUE   = 16'hF0D0;

  typedef enum logic [1:0] {
    INIT_STRAP,
    INIT_RUNNING,
    INIT_DONE
  } dir_init_state_type;

  // true when a byte address selects the given register index
  function automatic logic dir_hit(input logic [31:0] adr,
                                   input logic [15:0] idx);
    return adr[31:2] == {14'h0000, idx};
  endfunction

endpackage

`default_nettype wire

//--- src/dir_init_track.sv
// tracks whether the on-chip flash has finished initializing.
// assumes the external access pin is stable around reset release and
// that the flash controller raises init_done_i once it has finished.
`default_nettype none

module dir_init_track
  import dir_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic external_access_pin_i,
  input  wire logic init_done_i,
  output var  logic ready_o
);

  dir_init_state_type state_q;

  // ==========================================================
  // strap capture and completion
  // the pin level is taken at the first edge after release, so the
  // reset branch loads only constants
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= INIT_STRAP;
    end else begin
      case (state_q)
        INIT_STRAP: begin
          if (external_access_pin_i || init_done_i) begin
            state_q <= INIT_DONE;
          end else begin
            state_q <= INIT_RUNNING;
          end
        end
        INIT_RUNNING: begin
          if (init_done_i) begin
            state_q <= INIT_DONE;
          end
        end
        INIT_DONE: begin
          state_q <= INIT_DONE;
        end
        default: begin
          state_q <= INIT_STRAP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      case (state_q)
        INIT_STRAP:   ready_o <= external_access_pin_i || init_done_i;
        INIT_RUNNING: ready_o <= init_done_i;
        INIT_DONE:    ready_o <= 1'b1;
        default:      ready_o <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- src/dir_id_regs.sv
// identification register bank behind a classic wishbone slave.
// assumes one clock and a synchronous active-high reset; the flash
// controller reports init completion on flash_init_done_i.
//
// How it works
// - four read-only id registers sit in the extended register space.
// - software cannot change any id register.
// - maker register holds maker code on top, fixed bits below.
// - part register holds fixed part code and a 4-bit silicon revision.
// - memory size field is size in kbytes over four, 832 kbytes here.
// - memory kind field reports high-performance flash, code 3.
// - supply field is volts times 256 over 20, 40h for 5 V.
// - high-voltage field reads 00h, no external supply needed.
// - id contents are only trusted after flash init has finished.
// - internal boot (pin high at reset) means init already done.
// - external boot (pin low at reset) leaves id values not yet valid.
// - before init, memory reads F0D0h and voltage reads 0040h.
//
// The Wishbone interface to the registers was chosen for this implementation.
`default_nettype none

module dir_id_regs
  import dir_pkg::*;
#(
  // arbitrary identity values, not those of any real part
  parameter logic [10:0] MAKER_CODE = 11'h2A5,
  parameter logic [11:0] PART_CODE  = 12'h7C3,
  parameter logic [3:0]  SILICON_REV = 4'h1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        external_access_pin_i,
  input  wire logic        flash_init_done_i,
  output var  logic        flash_ready_o
);

  logic        ready;
  logic        req;
  logic [15:0] rd_word;
  logic [15:0] maker_word;
  logic [15:0] part_word;
  logic [15:0] mem_word;
  logic [15:0] prog_word;

  // ==========================================================
  // flash init tracking
  dir_init_track u_init (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .external_access_pin_i (external_access_pin_i),
    .init_done_i           (flash_init_done_i),
    .ready_o               (ready)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_ready_o <= 1'b0;
    end else begin
      flash_ready_o <= ready;
    end
  end

  // ==========================================================
  // register contents
  assign maker_word = {MAKER_CODE, MAKER_LOW_BITS};
  assign part_word  = {PART_CODE, SILICON_REV};
  // top memory bits stay set until flash init completes
  assign mem_word   = ready ? {MEM_KIND_HPFLASH, MEM_SIZE_FIELD}
                            : MEM_BUSY_VALUE;
  assign prog_word  = {PROG_HV_FIELD, PROG_SUPPLY_FIELD};

  always_comb begin
    rd_word = 16'h0000;
    if (dir_hit(wb_adr_i, IDX_MAKER_CODE)) begin
      rd_word = maker_word;
    end else if (dir_hit(wb_adr_i, IDX_PART_CODE)) begin
      rd_word = part_word;
    end else if (dir_hit(wb_adr_i, IDX_MEMORY)) begin
      rd_word = mem_word;
    end else if (dir_hit(wb_adr_i, IDX_PROG_VOLT)) begin
      rd_word = prog_word;
    end
  end

  // ==========================================================
  // wishbone slave
  // every access is answered one cycle after it is taken; unmapped
  // reads and all writes return zero
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {16'h0000, rd_word};
    end else if (req) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [15:0] ack_word;
  logic        rd_ack;
  logic [3:0]  since_rst_q;
  logic [31:0] taken_adr_q;
  logic        taken_we_q;
  logic        taken_ready_q;

  assign ack_word = wb_dat_o[15:0];
  assign rd_ack   = wb_ack_o && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_rst_q <= 4'h0;
    end else if (since_rst_q != 4'hF) begin
      since_rst_q <= since_rst_q + 4'h1;
    end
  end

  // the last taken access, kept so that each answer can be judged
  // against what was asked even if the master moves its address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_adr_q   <= 32'h0000_0000;
      taken_we_q    <= 1'b0;
      taken_ready_q <= 1'b0;
    end else if (req) begin
      taken_adr_q   <= wb_adr_i;
      taken_we_q    <= wb_we_i;
      taken_ready_q <= ready;
    end
  end

  ack_single_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high two cycles");

  ack_follows_req_a: assert property (
    req |=> wb_ack_o)
    else $error("request not answered in one cycle");

  maker_value_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MAKER_CODE)
      |-> ack_word == {MAKER_CODE, MAKER_LOW_BITS})
    else $error("maker word wrong");

  part_rev_value_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_PART_CODE)
      |-> ack_word[3:0] == SILICON_REV
          && ack_word[15:PART_FIELD_LSB] == PART_CODE)
    else $error("part or revision field wrong");

  mem_size_value_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MEMORY)
      |-> ack_word[11:0] == 12'h0D0)
    else $error("memory size field wrong");

  mem_kind_ready_a: assert property (
    ready && req && !wb_we_i && dir_hit(wb_adr_i, IDX_MEMORY)
      |=> ack_word == MEM_RESET_VALUE)
    else $error("memory word after init wrong");

  prog_value_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_PROG_VOLT)
      |-> ack_word == PROG_RESET_VALUE)
    else $error("voltage word wrong");

  busy_pattern_a: assert property (
    !ready && req && !wb_we_i && dir_hit(wb_adr_i, IDX_MEMORY)
      |=> ack_word == MEM_BUSY_VALUE)
    else $error("memory word before init wrong");

  ready_sticks_a: assert property (
    ready |=> ready)
    else $error("init ready fell");

  internal_boot_a: assert property (
    since_rst_q == 4'h0 && external_access_pin_i |=> ready)
    else $error("internal boot not ready at once");

  external_boot_a: assert property (
    since_rst_q == 4'h0 && !external_access_pin_i && !flash_init_done_i
      |=> !ready)
    else $error("external boot ready too early");

  done_sets_ready_a: assert property (
    flash_init_done_i |=> ready ##1 flash_ready_o)
    else $error("init done not reflected in two cycles");

  write_ignored_a: assert property (
    wb_ack_o && wb_we_i && !flash_init_done_i |-> wb_dat_o == 32'h0000_0000
      ##1 $stable(ready))
    else $error("write returned data or changed state");

  upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  unmapped_zero_a: assert property (
    rd_ack && !dir_hit(wb_adr_i, IDX_MAKER_CODE)
      && !dir_hit(wb_adr_i, IDX_PART_CODE)
      && !dir_hit(wb_adr_i, IDX_MEMORY)
      && !dir_hit(wb_adr_i, IDX_PROG_VOLT)
      |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  ack_needs_req_a: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without a taken request");

  data_holds_a: assert property (
    !req |=> $stable(wb_dat_o))
    else $error("read data moved without an access");

  write_zero_a: assert property (
    wb_ack_o && taken_we_q |-> wb_dat_o == 32'h0000_0000)
    else $error("write answered with data");

  mem_taken_a: assert property (
    wb_ack_o && !taken_we_q && dir_hit(taken_adr_q, IDX_MEMORY)
      |-> ack_word == (taken_ready_q ? MEM_RESET_VALUE : MEM_BUSY_VALUE))
    else $error("memory word does not match init state");

  maker_low_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MAKER_CODE)
      |-> ack_word[MAKER_FIELD_LSB-1:0] == MAKER_LOW_BITS)
    else $error("maker fixed bits wrong");

  mem_kind_code_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MEMORY)
      |-> (ack_word[15:MEM_KIND_LSB] == MEM_KIND_HPFLASH
          || ack_word[15:MEM_KIND_LSB] == MEM_KIND_BUSY))
    else $error("memory kind code wrong");

  prog_hv_zero_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_PROG_VOLT)
      |-> ack_word[15:PROG_HV_LSB] == PROG_HV_FIELD)
    else $error("high-voltage field not zero");

  prog_supply_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_PROG_VOLT)
      |-> ack_word[PROG_HV_LSB-1:0] == PROG_SUPPLY_FIELD)
    else $error("supply field wrong");

  busy_clear_ready_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MEMORY) && ack_word[15:14] == 2'h0
      |-> flash_ready_o)
    else $error("busy bits clear before id values valid");

  busy_set_waiting_a: assert property (
    rd_ack && dir_hit(wb_adr_i, IDX_MEMORY) && ack_word[15:14] == 2'h3
      |-> !flash_ready_o)
    else $error("busy bits set after id values valid");

  ready_lags_a: assert property (
    ready |=> flash_ready_o)
    else $error("ready output did not follow");

  not_ready_lags_a: assert property (
    !ready |=> !flash_ready_o)
    else $error("ready output rose too early");

  ready_needs_done_a: assert property (
    since_rst_q != 4'h0 && !ready && !flash_init_done_i |=> !ready)
    else $error("ready rose without init done");

  busy_read_c: cover property (
    rd_ack && dir_hit(wb_adr_i, IDX_MEMORY) && ack_word[15:14] == 2'b11);

  init_finish_c: cover property (!ready ##1 ready);

  maker_read_c: cover property (
    rd_ack && dir_hit(wb_adr_i, IDX_MAKER_CODE));

  write_try_c: cover property (
    wb_ack_o && wb_we_i && dir_hit(wb_adr_i, IDX_PART_CODE));

  internal_boot_c: cover property (
    since_rst_q == 4'h0 && external_access_pin_i);

endmodule

`default_nettype wire

//--- dv/device_identification_regs_bench.sv
// self-checking bench for the identification register bank.
// assumes dir_id_regs with its default identity parameters and a
// bench-driven wishbone master, boot strap and flash init input.
`default_nettype none

module device_identification_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin_q = 1'b1;
  logic        done_q = 1'b0;
  logic        flash_ready_o;
  logic [31:0] lfsr_q = 32'h5BAC;
  logic [31:0] rd_q;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles_q = 0;
  bit          model_ready = 1'b0;

  dir_id_regs dir_id_regs_i (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .wb_cyc_i              (wb_cyc_i),
    .wb_stb_i              (wb_stb_i),
    .wb_we_i               (wb_we_i),
    .wb_adr_i              (wb_adr_i),
    .wb_sel_i              (wb_sel_i),
    .wb_dat_i              (wb_dat_i),
    .wb_dat_o              (wb_dat_o),
    .wb_ack_o              (wb_ack_o),
    .external_access_pin_i (pin_q),
    .flash_init_done_i     (done_q),
    .flash_ready_o         (flash_ready_o)
  );

  // ==========================================================
  // clock, timeout, random source
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles_q <= cycles_q + 1;
    if (cycles_q == 5000) begin
      failures++;
      finish_test();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // ==========================================================
  // behavioural model of the readable words
  function automatic logic [31:0] model(input logic [31:0] a, input bit r);
    case (a[31:2])
      30'h0000F078: return {24'h0, 8'(5 * 256 / 20)};
      30'h0000F07A: return {16'h0, r ? 4'h3 : 4'hF, 12'(832 / 4)};
      30'h0000F07C: return {16'h0, 12'h7C3, 4'h1};
      30'h0000F07E: return {16'h0, 11'h2A5, 5'h03};
      default:      return 32'h0;
    endcase
  endfunction

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // ==========================================================
  // wishbone classic master
  task automatic wb_xfer(input logic w, input logic [31:0] a);
    @(posedge clk_i);
    lfsr_q = lfsr_next(lfsr_q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= lfsr_q[3:0];
    wb_dat_i <= lfsr_q;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic read_all(input string n);
    for (int k = 0; k < 5; k++) begin
      wb_xfer(1'b0, 32'h0003C1E0 + 32'(k * 8) - 32'(k == 4) * 28);
      check(n, model(wb_adr_i, model_ready), rd_q);
    end
  endtask

  task automatic do_reset(input logic p);
    rst_i  <= 1'b1;
    pin_q  <= p;
    done_q <= 1'b0;
    model_ready = p;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    do_reset(1'b1);
    check("ready_internal", 32'(1'b1), 32'(flash_ready_o));
    read_all("internal_boot");
    $display("test internal_boot done");
    for (int k = 0; k < 4; k++) begin
      wb_xfer(1'b1, 32'h0003C1E0 + 32'(k * 8) + 32'(lfsr_q[1:0]));
      check("write_data", 32'h0, rd_q);
    end
    read_all("after_writes");
    $display("test writes_ignored done");
    do_reset(1'b0);
    check("ready_external", 32'h0, 32'(flash_ready_o));
    read_all("before_init");
    // poll the busy bits as software would; init ends during the poll
    for (int k = 0; k < 8; k++) begin
      if (k == 2) begin
        done_q <= 1'b1;
        model_ready = 1'b1;
      end
      wb_xfer(1'b0, 32'h0003C1E8);
      check("poll_word", model(wb_adr_i, model_ready), rd_q);
      if (rd_q[15:14] === 2'h0)
        break;
    end
    done_q <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("busy_bits", 32'h0, 32'(rd_q[15:14]));
    check("ready_after", 32'(1'b1), 32'(flash_ready_o));
    read_all("after_init");
    $display("test external_boot done");
    finish_test();
  end

endmodule

`default_nettype wire
